/* File: rtl/watch_link_mask_vector_catch.sv */
// Watchpoint link/mask compare and vector catch event logic with register port
// Operation
// [R1] Linked breakpoint number picks the breakpoint unit a watchpoint combines with.
// [R2] Software keeps the linked number zero while linking is off.
// [R3] Linking on makes the watch hit need the selected breakpoint unit match.
// [R4] Software sets the linked breakpoint unit for context-ID matching.
// [R5] Mask value n of three or more drops the low n address bits.
// [R6] Without mask support the mask field reads zero and ignores writes.
// [R7] Software sets all byte-select bits whenever the mask is nonzero.
// [R8] Software zeroes value bits that the mask removes.
// [R9] Debuggers use mask three with all byte selects for 8-byte objects.
// [R10] Enabled catch plus committed fetch from its vector raises a debug event.
// [R11] Catch compares the vector's upper 30 bits, hitting any byte of the word.
// [R12] Catch fires on any fetch from the vector, exception entry or not.
// [R13] Low byte catch bits seven, six and four to zero always exist.
// [R14] Upper catch bits exist only with security extensions, else read zero.
// [R15] With upper bits, bits 15:0 catch secure only, 31:25 nonsecure only.
// [R16] Nonsecure catches use nonsecure base plus offset, or high vectors.
// [R17] Monitor catches use monitor base plus offset, unaffected by high vectors.
// [R18] Secure low catches use secure base or high vectors; reset is absolute.
// [R19] Vectored interrupts make irq and fiq catches use latest handler address.
// [R20] Without security extensions catches use fixed absolute or high addresses.
// [R21] Security extensions with low byte only catch in either world, current base.
// [R22] Catch bits reset to zero; debugger programs them before enabling debug.
// [R23] Watch enable gates the watchpoint; link and mask act only when enabled.
// [R24] A catch is one event, given only for a committing instruction.
//
// The implementer's own choice: the address-and-strobe port.
module watch_link_mask_vector_catch #(
    parameter int NUM_WATCH = 4,
    parameter int NUM_BREAK = 16,
    parameter int BAS_BITS = 8,
    parameter bit MASK_IMPL = 1'b1,
    parameter bit SECURITY_EXT = 1'b1,
    parameter bit UPPER_CATCH = 1'b1
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Register port
    input wire logic [11:0] i_address,
    input wire logic [31:0] i_write_data,
    input wire logic i_write_strobe,
    input wire logic i_read_strobe,
    output logic [31:0] o_read_data,
    // Processor state
    input wire logic i_secure_world,
    input wire logic i_high_vectors,
    input wire logic i_vectored_irq_enable,
    input wire dbg_match_pkg::vector_bases_t i_bases,
    // Instruction fetch path
    input wire logic [31:0] i_fetch_addr,
    input wire logic i_fetch_commit,
    // Load/store path
    input wire logic [31:0] i_data_addr,
    input wire logic i_data_valid,
    input wire logic [NUM_BREAK-1:0] i_break_link_match,
    // Debug events
    output logic o_vector_catch,
    output logic [31:0] o_vector_catch_bits,
    output logic [NUM_WATCH-1:0] o_watch_hit
);

    // Sizes beyond the 12-bit decode and 4-bit link select are refused
    if (NUM_WATCH < 1 || NUM_WATCH > 16) begin : gen_bad_watch
        $error("NUM_WATCH must be 1 to 16");
    end
    if (NUM_BREAK < 1 || NUM_BREAK > 16) begin : gen_bad_break
        $error("NUM_BREAK must be 1 to 16");
    end
    if (BAS_BITS != 4 && BAS_BITS != 8) begin : gen_bad_bas
        $error("BAS_BITS must be 4 or 8");
    end
    // Upper catch bits only make sense with a world split
    if (UPPER_CATCH && !SECURITY_EXT) begin : gen_bad_upper
        $error("UPPER_CATCH needs SECURITY_EXT");
    end

    localparam int LANE_W = (BAS_BITS == 8) ? 3 : 2;
    localparam logic [31:0] VC_IMPL = UPPER_CATCH ?
        (dbg_match_pkg::VC_LOW_BITS | dbg_match_pkg::VC_UPPER_BITS) :
        dbg_match_pkg::VC_LOW_BITS;
    localparam logic [7:0] BAS_IMPL = (BAS_BITS == 8) ? 8'hff : 8'h0f;

    // Mask value to address mask; reserved values mask nothing
    function automatic logic [31:0] mask_of(input logic [4:0] m);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (m >= dbg_match_pkg::WC_MASK_FIRST_LEGAL)
            r = (32'h0000_0001 << m) - 32'h0000_0001;
        return r;
    endfunction

    function automatic logic word_match(input logic [31:0] a, input logic [31:0] b);
        return a[31:2] == b[31:2];
    endfunction

    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Register state
    logic [31:0] vcatch_q;
    logic [31:0] vcatch_status_q;
    logic [31:0] watch_value_q [NUM_WATCH];
    dbg_match_pkg::watch_ctrl_t watch_ctrl_q [NUM_WATCH];

    logic wr_vcatch;
    logic [NUM_WATCH-1:0] wr_wvalue;
    logic [NUM_WATCH-1:0] wr_wctrl;

    always_comb begin
        wr_vcatch = i_write_strobe && i_address == dbg_match_pkg::VCATCH_OFFSET;
        for (int n = 0; n < NUM_WATCH; n++) begin
            wr_wvalue[n] = i_write_strobe &&
                i_address == dbg_match_pkg::WATCH_VALUE_BASE + 12'(4 * n);
            wr_wctrl[n] = i_write_strobe &&
                i_address == dbg_match_pkg::WATCH_CONTROL_BASE + 12'(4 * n);
        end
    end

    // Defined reset for every catch bit, absent bits never store
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q)
            vcatch_q <= dbg_match_pkg::VCATCH_RESET; // [R22]
        else if (wr_vcatch)
            vcatch_q <= i_write_data & VC_IMPL; // [R13] [R14]
    end

    genvar g;
    generate
        for (g = 0; g < NUM_WATCH; g++) begin : gen_watch_regs
            always_ff @(posedge i_clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    watch_value_q[g] <= dbg_match_pkg::WORD_RESET;
                end else if (wr_wvalue[g]) begin
                    watch_value_q[g] <= {i_write_data[31:2], 2'b00};
                end
            end

            always_ff @(posedge i_clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    watch_ctrl_q[g] <= dbg_match_pkg::WATCH_CTRL_RESET;
                end else if (wr_wctrl[g]) begin
                    watch_ctrl_q[g].en <= i_write_data[dbg_match_pkg::WC_ENABLE_POS];
                    // Upper selects drop on narrow units so one program suits both
                    watch_ctrl_q[g].bas <= i_write_data[dbg_match_pkg::WC_BAS_LSB +: 8]
                        & BAS_IMPL; // [R9]
                    watch_ctrl_q[g].link_bp <= i_write_data[dbg_match_pkg::WC_LINK_BP_LSB +: 4];
                    watch_ctrl_q[g].link_en <= i_write_data[dbg_match_pkg::WC_LINK_EN_POS];
                    watch_ctrl_q[g].mask <= MASK_IMPL ?
                        i_write_data[dbg_match_pkg::WC_MASK_LSB +: 5] : 5'h00; // [R6]
                end
            end
        end
    endgenerate

    // Read port, data valid only in the cycle after the strobe
    logic [31:0] read_d;

    always_comb begin
        read_d = 32'h0000_0000;
        if (i_address == dbg_match_pkg::VCATCH_OFFSET)
            read_d = vcatch_q & VC_IMPL; // [R14]
        if (i_address == dbg_match_pkg::VCATCH_STATUS_OFFSET)
            read_d = vcatch_status_q;
        for (int n = 0; n < NUM_WATCH; n++) begin
            if (i_address == dbg_match_pkg::WATCH_VALUE_BASE + 12'(4 * n))
                read_d = watch_value_q[n];
            if (i_address == dbg_match_pkg::WATCH_CONTROL_BASE + 12'(4 * n)) begin
                read_d[dbg_match_pkg::WC_ENABLE_POS] = watch_ctrl_q[n].en;
                read_d[dbg_match_pkg::WC_BAS_LSB +: 8] = watch_ctrl_q[n].bas;
                read_d[dbg_match_pkg::WC_LINK_BP_LSB +: 4] = watch_ctrl_q[n].link_bp;
                read_d[dbg_match_pkg::WC_LINK_EN_POS] = watch_ctrl_q[n].link_en;
                read_d[dbg_match_pkg::WC_MASK_LSB +: 5] = watch_ctrl_q[n].mask;
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q)
            o_read_data <= 32'h0000_0000;
        else if (i_read_strobe)
            o_read_data <= read_d;
        else
            o_read_data <= 32'h0000_0000;
    end

    // Watchpoint compare
    logic [NUM_WATCH-1:0] watch_hit_d;

    always_comb begin
        logic [31:0] cmp_mask;
        logic [31:0] lane_mask;
        logic addr_ok;
        logic lane_ok;
        logic link_ok;
        cmp_mask = 32'h0000_0000;
        lane_mask = 32'h0000_0000;
        addr_ok = 1'b0;
        lane_ok = 1'b0;
        link_ok = 1'b0;
        for (int n = 0; n < NUM_WATCH; n++) begin
            lane_mask = (32'h0000_0001 << LANE_W) - 32'h0000_0001;
            cmp_mask = mask_of(watch_ctrl_q[n].mask) | lane_mask; // [R5]
            addr_ok = (i_data_addr & ~cmp_mask) == (watch_value_q[n] & ~cmp_mask);
            // Masked ranges expect all selects set, so the lane test stays valid
            lane_ok = watch_ctrl_q[n].bas[i_data_addr[LANE_W-1:0]];
            // Link select beyond the last unit never matches
            link_ok = !watch_ctrl_q[n].link_en; // [R3]
            if (watch_ctrl_q[n].link_en && int'(watch_ctrl_q[n].link_bp) < NUM_BREAK)
                link_ok = i_break_link_match[watch_ctrl_q[n].link_bp]; // [R1] [R3]
            watch_hit_d[n] = watch_ctrl_q[n].en && i_data_valid &&
                addr_ok && lane_ok && link_ok; // [R23]
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q)
            o_watch_hit <= '0;
        else
            o_watch_hit <= watch_hit_d;
    end

    // Vector catch targets, slot offset is slot index times four
    logic [31:0] catch_hits;

    always_comb begin
        logic [31:0] base;
        logic [31:0] target;
        logic world_ok;
        logic [2:0] slot;
        base = 32'h0000_0000;
        target = 32'h0000_0000;
        world_ok = 1'b0;
        slot = 3'h0;
        for (int i = 0; i < 32; i++) begin
            slot = 3'(i);
            world_ok = 1'b1;
            if (i < 8) begin
                if (!SECURITY_EXT)
                    base = dbg_match_pkg::VC_LOW_BASE; // [R20]
                else if (UPPER_CATCH)
                    base = i_bases.secure_vector_base; // [R18]
                else
                    base = i_secure_world ? i_bases.secure_vector_base :
                        i_bases.nonsecure_vector_base; // [R21]
                if (i_high_vectors)
                    base = dbg_match_pkg::VC_HIGH_BASE;
                if (UPPER_CATCH)
                    world_ok = i_secure_world; // [R15]
            end else if (i < 16) begin
                base = i_bases.monitor_vector_base; // [R17]
                world_ok = i_secure_world; // [R15]
            end else begin
                base = i_high_vectors ? dbg_match_pkg::VC_HIGH_BASE :
                    i_bases.nonsecure_vector_base; // [R16]
                world_ok = !i_secure_world; // [R15]
            end
            target = base + {27'h0000000, slot, 2'b00};
            if (i == dbg_match_pkg::VC_RESET_SLOT)
                target = i_high_vectors ? dbg_match_pkg::VC_HIGH_BASE :
                    dbg_match_pkg::VC_LOW_BASE; // [R18]
            if (i_vectored_irq_enable && (i < 8 || i >= 24)) begin
                // Secure handlers in the low byte when upper bits exist, world is secure or security extensions are absent
                if (slot == 3'(dbg_match_pkg::VC_IRQ_SLOT))
                    target = (i < 8 && (UPPER_CATCH || i_secure_world || !SECURITY_EXT)) ?
                        i_bases.secure_irq_addr : i_bases.nonsecure_irq_addr; // [R19]
                if (slot == 3'(dbg_match_pkg::VC_FIQ_SLOT))
                    target = (i < 8 && (UPPER_CATCH || i_secure_world || !SECURITY_EXT)) ?
                        i_bases.secure_fiq_addr : i_bases.nonsecure_fiq_addr; // [R19]
            end
            // Any fetch inside the vector word counts
            catch_hits[i] = vcatch_q[i] && VC_IMPL[i] && world_ok &&
                word_match(i_fetch_addr, target); // [R10] [R11] [R12]
        end
    end

    // One event per committed instruction; discarded fetches never commit
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_vector_catch <= 1'b0;
            o_vector_catch_bits <= 32'h0000_0000;
        end else begin
            o_vector_catch <= i_fetch_commit && |catch_hits; // [R24] [R10]
            o_vector_catch_bits <= i_fetch_commit ? catch_hits : 32'h0000_0000;
        end
    end

    // Last caught bits, kept until the next catch
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q)
            vcatch_status_q <= 32'h0000_0000;
        else if (i_fetch_commit && |catch_hits)
            vcatch_status_q <= catch_hits;
    end

endmodule

/* File: rtl/dbg_match_pkg.sv */
// Shared constants and carriers for watchpoint linking, masking and vector catch
package dbg_match_pkg;

    // Register byte offsets
    localparam logic [11:0] VCATCH_OFFSET = 12'h01c;
    localparam logic [11:0] VCATCH_STATUS_OFFSET = 12'h0f0;
    localparam logic [11:0] WATCH_VALUE_BASE = 12'h180;
    localparam logic [11:0] WATCH_CONTROL_BASE = 12'h1c0;

    // Watch control field positions
    localparam int WC_ENABLE_POS = 0;
    localparam int WC_BAS_LSB = 5;
    localparam int WC_LINK_BP_LSB = 16;
    localparam int WC_LINK_EN_POS = 20;
    localparam int WC_MASK_LSB = 24;
    localparam logic [4:0] WC_MASK_FIRST_LEGAL = 5'h03;

    // Implemented catch bits
    localparam logic [31:0] VC_LOW_BITS = 32'h0000_00df;
    localparam logic [31:0] VC_UPPER_BITS = 32'hde00_dc00;

    // Vector addresses
    localparam logic [31:0] VC_LOW_BASE = 32'h0000_0000;
    localparam logic [31:0] VC_HIGH_BASE = 32'hffff_0000;
    localparam int VC_IRQ_SLOT = 6;
    localparam int VC_FIQ_SLOT = 7;
    localparam int VC_RESET_SLOT = 0;

    // Reset values
    localparam logic [31:0] VCATCH_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [4:0] mask;
        logic link_en;
        logic [3:0] link_bp;
        logic [7:0] bas;
        logic en;
    } watch_ctrl_t;

    typedef struct packed {
        logic [31:0] secure_vector_base;
        logic [31:0] nonsecure_vector_base;
        logic [31:0] monitor_vector_base;
        logic [31:0] secure_irq_addr;
        logic [31:0] secure_fiq_addr;
        logic [31:0] nonsecure_irq_addr;
        logic [31:0] nonsecure_fiq_addr;
    } vector_bases_t;

    localparam watch_ctrl_t WATCH_CTRL_RESET = '{
        mask: 5'h00, link_en: 1'b0, link_bp: 4'h0, bas: 8'h00, en: 1'b0};

endpackage

/* File: testbench/wlmvc_properties.sv */
// Concurrent checks on read timing, catch events and watch hits
module wlmvc_properties #(
    parameter int NUM_WATCH = 4
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_read_strobe,
    input wire logic [31:0] o_read_data,
    input wire logic i_secure_world,
    input wire logic i_high_vectors,
    input wire dbg_match_pkg::vector_bases_t i_bases,
    input wire logic [31:0] i_fetch_addr,
    input wire logic i_fetch_commit,
    input wire logic i_data_valid,
    input wire logic o_vector_catch,
    input wire logic [31:0] o_vector_catch_bits,
    input wire logic [NUM_WATCH-1:0] o_watch_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    sequence s_idle_fetch;
        !i_fetch_commit;
    endsequence
    sequence s_any_hit;
        o_vector_catch_bits != 32'h0;
    endsequence
    a_read_idle_zero: assert property (!$past(i_read_strobe) |-> o_read_data == 32'h0)
        else $error("read data outside answer cycle");
    a_catch_needs_commit: assert property (s_idle_fetch |=> !o_vector_catch)
        else $error("catch without commit");
    a_bits_with_pulse: assert property (s_any_hit |-> o_vector_catch)
        else $error("catch bits without pulse");
    a_bits_implemented: assert property (
        (o_vector_catch_bits & ~dbg_match_pkg::VC_LOW_BITS
        & ~dbg_match_pkg::VC_UPPER_BITS) == 32'h0)
        else $error("unimplemented catch bit fired");
    a_secure_only: assert property (
        |o_vector_catch_bits[15:0] |-> $past(i_secure_world))
        else $error("low catch outside secure world");
    a_nonsecure_only: assert property (
        |o_vector_catch_bits[31:25] |-> !$past(i_secure_world))
        else $error("upper catch in secure world");
    a_reset_vector: assert property (
        o_vector_catch_bits[0] |-> ($past(i_fetch_addr) & 32'hffff_fffc)
        == ($past(i_high_vectors) ? 32'hffff_0000 : 32'h0))
        else $error("reset catch at wrong address");
    a_monitor_call: assert property (
        o_vector_catch_bits[10] |-> ($past(i_fetch_addr) & 32'hffff_fffc)
        == $past(i_bases.monitor_vector_base) + 32'h8)
        else $error("monitor call catch at wrong address");
    a_watch_needs_access: assert property (|o_watch_hit |-> $past(i_data_valid))
        else $error("watch hit without access");
endmodule

bind watch_link_mask_vector_catch wlmvc_properties #(.NUM_WATCH(NUM_WATCH)) i_wlmvc_properties (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_read_strobe(i_read_strobe),
    .o_read_data(o_read_data), .i_secure_world(i_secure_world), .i_high_vectors(i_high_vectors),
    .i_bases(i_bases), .i_fetch_addr(i_fetch_addr), .i_fetch_commit(i_fetch_commit),
    .i_data_valid(i_data_valid), .o_vector_catch(o_vector_catch),
    .o_vector_catch_bits(o_vector_catch_bits), .o_watch_hit(o_watch_hit)
);

/* File: testbench/debugger_model.sv */
// Debugger model driving the register port
module debugger_model (
    input wire logic i_clock,
    input wire logic [31:0] i_read_data,
    output logic [11:0] o_address,
    output logic [31:0] o_write_data,
    output logic o_write_strobe,
    output logic o_read_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_address = 12'h0;
        o_write_data = 32'h0;
        o_write_strobe = 1'b0;
        o_read_strobe = 1'b0;
    end
    task automatic write_reg(input logic [11:0] addr, input logic [31:0] data);
        @(posedge i_clock);
        o_address <= addr;
        o_write_data <= data;
        o_write_strobe <= 1'b1;
        @(posedge i_clock);
        o_write_strobe <= 1'b0;
        // Stale data inverted so nothing leans on a held value
        o_write_data <= ~data;
    endtask
    task automatic read_reg(input logic [11:0] addr, output logic [31:0] data);
        @(posedge i_clock);
        o_address <= addr;
        o_read_strobe <= 1'b1;
        @(posedge i_clock);
        o_read_strobe <= 1'b0;
        @(negedge i_clock);
        data = i_read_data;
    endtask
endmodule

/* File: testbench/watch_link_mask_vector_catch_tb_top.sv */
// Self-checking bench for watch linking, masking and vector catch
module watch_link_mask_vector_catch_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IMPL = dbg_match_pkg::VC_LOW_BITS | dbg_match_pkg::VC_UPPER_BITS;
    logic clock, resetn, wstb, rstb, secure, hv, virq, commit, dvalid, caught;
    logic [11:0] address;
    logic [31:0] wdata, rdata, fetch_addr, data_addr, cbits;
    logic [15:0] link_match;
    logic [3:0] hit;
    dbg_match_pkg::vector_bases_t bases;
    logic [31:0] seed = 32'ha69c9ed0;
    int fail_count = 0;
    int check_count = 0;

    watch_link_mask_vector_catch i_watch_link_mask_vector_catch (
        .i_clock(clock), .i_resetn(resetn), .i_address(address), .i_write_data(wdata),
        .i_write_strobe(wstb), .i_read_strobe(rstb), .o_read_data(rdata),
        .i_secure_world(secure), .i_high_vectors(hv), .i_vectored_irq_enable(virq),
        .i_bases(bases), .i_fetch_addr(fetch_addr), .i_fetch_commit(commit),
        .i_data_addr(data_addr), .i_data_valid(dvalid), .i_break_link_match(link_match),
        .o_vector_catch(caught), .o_vector_catch_bits(cbits), .o_watch_hit(hit));
    debugger_model i_debugger_model (.i_clock(clock), .i_read_data(rdata), .o_address(address),
        .o_write_data(wdata), .o_write_strobe(wstb), .o_read_strobe(rstb));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] vec_addr(input int b);
        logic [31:0] off;
        off = 32'(b % 8) * 32'h4;
        if (b == 0) return hv ? 32'hffff_0000 : 32'h0;
        if (b >= 8 && b < 16) return bases.monitor_vector_base + off;
        if (virq && b % 8 == 6) return b < 8 ? bases.secure_irq_addr : bases.nonsecure_irq_addr;
        if (virq && b % 8 == 7) return b < 8 ? bases.secure_fiq_addr : bases.nonsecure_fiq_addr;
        if (hv) return 32'hffff_0000 + off;
        return (b < 8 ? bases.secure_vector_base : bases.nonsecure_vector_base) + off;
    endfunction
    function automatic logic [31:0] wctl(input logic [4:0] m, input logic le, input logic [3:0] bp,
        input logic en);
        return {3'h0, m, 3'h0, le, bp, 3'h0, 8'hff, 4'h0, en};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic fetch(input logic [31:0] a, input logic world, input logic [31:0] exp);
        @(posedge clock);
        fetch_addr <= a;
        secure <= world;
        commit <= 1'b1;
        @(posedge clock);
        commit <= 1'b0;
        fetch_addr <= ~a;
        @(negedge clock);
        check("catch bits", exp, cbits);
        check("catch pulse", {31'h0, exp != 32'h0}, {31'h0, caught});
    endtask
    task automatic access(input logic [31:0] a, input logic [3:0] exp);
        @(posedge clock);
        data_addr <= a;
        dvalid <= 1'b1;
        @(posedge clock);
        dvalid <= 1'b0;
        data_addr <= ~a;
        @(negedge clock);
        check("watch hit", {28'h0, exp}, {28'h0, hit});
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        #(25 * 20000);
        fail_count++;
        close_out();
    end
    initial begin
        logic [31:0] v;
        logic [31:0] a;
        {resetn, secure, hv, virq, commit, dvalid} = 6'h0;
        {bases, fetch_addr, data_addr, link_match} = '0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        i_debugger_model.read_reg(12'h01c, v);
        check("catch reset", 32'h0, v);
        i_debugger_model.write_reg(12'h01c, 32'hffff_ffff);
        i_debugger_model.read_reg(12'h01c, v);
        check("catch implemented", IMPL, v);
        i_debugger_model.write_reg(12'h1c0, 32'hffff_ffff);
        i_debugger_model.read_reg(12'h1c0, v);
        check("watch control", 32'h1f1f_1fe1, v);
        i_debugger_model.read_reg(12'h004, v);
        check("unmapped", 32'h0, v);
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 32; b++) begin
                if (IMPL[b]) begin
                    i_debugger_model.write_reg(12'h01c, 32'h1 << b);
                    @(posedge clock);
                    for (int k = 0; k < 7; k++) bases[k*32 +: 32] <= rnd() & 32'hffff_ffe0;
                    hv <= p[0];
                    virq <= p[0] ^ b[0];
                    @(negedge clock);
                    a = vec_addr(b) | (rnd() & 32'h3);
                    fetch(a, b < 16, 32'h1 << b);
                    fetch(a + 32'h4, b < 16, 32'h0);
                    fetch(a, b >= 16, 32'h0);
                    // Vector address shown in the right world but never committed
                    @(posedge clock);
                    fetch_addr <= a;
                    secure <= b < 16;
                    @(posedge clock);
                    @(negedge clock);
                    check("discarded fetch", 32'h0, cbits);
                end
            end
        end
        i_debugger_model.read_reg(12'h0f0, v);
        check("catch status", 32'h8000_0000, v);
        v = rnd() & 32'hffff_ff00;
        i_debugger_model.write_reg(12'h180, v);
        i_debugger_model.write_reg(12'h1c0, wctl(5'h00, 1'b0, 4'h0, 1'b1));
        access(v + 32'h3, 4'h1);
        access(v + 32'h8, 4'h0);
        i_debugger_model.write_reg(12'h1c0, wctl(5'h03, 1'b0, 4'h0, 1'b1));
        access(v + 32'h7, 4'h1);
        access(v + 32'h8, 4'h0);
        i_debugger_model.write_reg(12'h1c0, wctl(5'h07, 1'b0, 4'h0, 1'b1));
        access(v + 32'h7f, 4'h1);
        access(v + 32'h80, 4'h0);
        i_debugger_model.write_reg(12'h1c0, wctl(5'h08, 1'b0, 4'h0, 1'b1));
        access(v + 32'hff, 4'h1);
        access(v + 32'h100, 4'h0);
        i_debugger_model.write_reg(12'h1c0, wctl(5'h00, 1'b1, 4'h3, 1'b1));
        @(posedge clock);
        link_match <= 16'hfff7;
        access(v, 4'h0);
        @(posedge clock);
        link_match <= 16'h0008;
        access(v, 4'h1);
        i_debugger_model.write_reg(12'h1c0, wctl(5'h00, 1'b0, 4'h0, 1'b0));
        access(v, 4'h0);
        close_out();
    end
endmodule
